// >>> smcp_pkg.sv
// constants shared by the serial message command parser
package smcp_pkg;
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned DATA_BITS   = 7;
	localparam int unsigned FRAME_BITS  = 10;
	localparam int unsigned MAX_LEN     = 255;
	localparam int unsigned TMR_W       = 16;
	localparam logic [6:0]  CH_LF       = 7'h0a;
	localparam logic [6:0]  CH_CR       = 7'h0d;
	localparam logic [6:0]  CH_SPACE    = 7'h20;
	localparam logic [6:0]  CH_SEMI     = 7'h3b;
	localparam logic [6:0]  CH_QMARK    = 7'h3f;
	localparam logic [7:0]  LEN_MAX     = 8'hff;
	localparam logic [3:0]  NBIT_LAST   = 4'h7;
	localparam logic [3:0]  NBIT_FRAME  = 4'ha;
	localparam logic [9:0]  TX_IDLE_SH  = 10'h3ff;

	typedef enum logic [1:0] {
		SMCP_RX_IDLE  = 2'b00,
		SMCP_RX_START = 2'b01,
		SMCP_RX_BITS  = 2'b10,
		SMCP_RX_STOP  = 2'b11
	} smcp_rx_t;

	typedef enum logic [0:0] {
		SMCP_P_COLLECT = 1'b0,
		SMCP_P_REPLAY  = 1'b1
	} smcp_p_t;

	typedef enum logic [1:0] {
		SMCP_TS_DATA = 2'b00,
		SMCP_TS_CR   = 2'b01,
		SMCP_TS_LF   = 2'b10
	} smcp_ts_t;
endpackage : smcp_pkg

// >>> smcp_parser.sv
// serial framer, message parser and response transmitter
// Operation
// - every character frame is ten bits with seven ASCII data bits.
// - each frame opens with one start bit and closes with one stop bit.
// - each frame carries one odd parity bit over the data bits.
// - a message ends on LF alone or on CR followed by LF.
// - every response leaves the device ending with CR then LF.
// - chained strings are separated by semicolons; the device splits there.
// - a command is mnemonic, space, parameters, terminator; it gets no reply.
// - mnemonic followed by question mark is a query and gets a response.
// - a query response is transmitted as soon as it is available.
// - the device never transmits except to answer an issued query.
module smcp_parser #(
	parameter int unsigned BAUD_RATE = 57600,
	parameter int unsigned CLKS_PER_BIT = smcp_pkg::CLK_HZ / BAUD_RATE
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ser_rx,
	output logic            ser_tx,
	output logic            out_valid,
	input  wire logic       out_ready,
	output logic [6:0]      out_char,
	output logic            out_param,
	output logic            out_end,
	output logic            out_query,
	input  wire logic       resp_valid,
	output logic            resp_ready,
	input  wire logic [6:0] resp_char,
	input  wire logic       resp_last,
	output logic            msg_drop
);
	localparam logic [15:0] BIT_T = 16'(CLKS_PER_BIT - 1);
	localparam logic [15:0] HALF_T = 16'(CLKS_PER_BIT / 2 - 1);

	// receive pin synchroniser
	logic rx_s1_reg;
	logic rx_s2_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
		end else begin
			rx_s1_reg <= ser_rx;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	// receive framer
	smcp_pkg::smcp_rx_t rx_st_reg, rx_st_next;
	logic [15:0] rx_cnt_reg, rx_cnt_next;
	logic [3:0]  rx_nb_reg, rx_nb_next;
	logic [7:0]  rx_sh_reg, rx_sh_next;
	logic        rx_done_reg, rx_done_next;
	logic        rx_bad_reg, rx_bad_next;
	logic [6:0]  rx_char_reg, rx_char_next;

	always_comb begin
		rx_st_next = rx_st_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_nb_next = rx_nb_reg;
		rx_sh_next = rx_sh_reg;
		rx_done_next = 1'b0;
		rx_bad_next = rx_bad_reg;
		rx_char_next = rx_char_reg;
		case (rx_st_reg)
			smcp_pkg::SMCP_RX_IDLE: begin
				if (!rx_s2_reg) begin
					rx_st_next = smcp_pkg::SMCP_RX_START;
					rx_cnt_next = HALF_T;
				end
			end
			smcp_pkg::SMCP_RX_START: begin
				if (rx_cnt_reg != 16'h0000) begin
					rx_cnt_next = rx_cnt_reg - 16'h0001;
				end else if (rx_s2_reg) begin
					rx_st_next = smcp_pkg::SMCP_RX_IDLE;
				end else begin
					rx_st_next = smcp_pkg::SMCP_RX_BITS;
					rx_cnt_next = BIT_T;
					rx_nb_next = 4'h0;
				end
			end
			smcp_pkg::SMCP_RX_BITS: begin
				if (rx_cnt_reg != 16'h0000) begin
					rx_cnt_next = rx_cnt_reg - 16'h0001;
				end else begin
					rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]};
					rx_cnt_next = BIT_T;
					rx_nb_next = rx_nb_reg + 4'h1;
					if (rx_nb_reg == smcp_pkg::NBIT_LAST) begin
						rx_st_next = smcp_pkg::SMCP_RX_STOP;
					end
				end
			end
			smcp_pkg::SMCP_RX_STOP: begin
				if (rx_cnt_reg != 16'h0000) begin
					rx_cnt_next = rx_cnt_reg - 16'h0001;
				end else begin
					rx_done_next = 1'b1;
					rx_char_next = rx_sh_reg[6:0];
					rx_bad_next = !rx_s2_reg || !(^rx_sh_reg);
					rx_st_next = smcp_pkg::SMCP_RX_IDLE;
				end
			end
			default: rx_st_next = smcp_pkg::SMCP_RX_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_reg <= smcp_pkg::SMCP_RX_IDLE;
			rx_cnt_reg <= 16'h0000;
			rx_nb_reg <= 4'h0;
			rx_sh_reg <= 8'h00;
			rx_done_reg <= 1'b0;
			rx_bad_reg <= 1'b0;
			rx_char_reg <= 7'h00;
		end else begin
			rx_st_reg <= rx_st_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_nb_reg <= rx_nb_next;
			rx_sh_reg <= rx_sh_next;
			rx_done_reg <= rx_done_next;
			rx_bad_reg <= rx_bad_next;
			rx_char_reg <= rx_char_next;
		end
	end

	// message store and parser
	logic [6:0] msg_mem [0:smcp_pkg::MAX_LEN-1];
	smcp_pkg::smcp_p_t p_st_reg, p_st_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] widx_reg, widx_next;
	logic [7:0] ridx_reg, ridx_next;
	logic       err_reg, err_next;
	logic       has_reg, has_next;
	logic       qry_reg, qry_next;
	logic       par_reg, par_next;
	logic       drop_reg, drop_next;
	logic       mem_we;
	logic [6:0] cur;
	logic       beat;
	logic       term;

	assign cur = msg_mem[ridx_reg];
	assign term = rx_done_reg && rx_char_reg == smcp_pkg::CH_LF;
	assign beat = out_valid && out_ready;
	assign out_char = cur;
	assign out_param = par_reg;
	assign out_query = qry_reg;
	assign msg_drop = drop_reg;

	always_comb begin
		p_st_next = p_st_reg;
		cnt_next = cnt_reg;
		widx_next = widx_reg;
		ridx_next = ridx_reg;
		err_next = err_reg;
		has_next = has_reg;
		qry_next = qry_reg;
		par_next = par_reg;
		drop_next = 1'b0;
		mem_we = 1'b0;
		out_valid = 1'b0;
		out_end = 1'b0;
		if (p_st_reg == smcp_pkg::SMCP_P_COLLECT) begin
			if (term) begin
				cnt_next = 8'h00;
				err_next = 1'b0;
				ridx_next = 8'h00;
				if (err_reg || rx_bad_reg || cnt_reg == smcp_pkg::LEN_MAX) begin
					drop_next = 1'b1;
					widx_next = 8'h00;
				end else begin
					p_st_next = smcp_pkg::SMCP_P_REPLAY;
				end
			end else if (rx_done_reg) begin
				if (rx_bad_reg || cnt_reg == smcp_pkg::LEN_MAX) begin
					err_next = 1'b1;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
				if (rx_char_reg != smcp_pkg::CH_CR && !err_next) begin
					mem_we = 1'b1;
					widx_next = widx_reg + 8'h01;
				end
			end
		end else begin
			if (ridx_reg == widx_reg || cur == smcp_pkg::CH_SEMI) begin
				out_valid = has_reg;
				out_end = 1'b1;
				if (out_ready || !has_reg) begin
					has_next = 1'b0;
					qry_next = 1'b0;
					par_next = 1'b0;
					if (ridx_reg == widx_reg) begin
						p_st_next = smcp_pkg::SMCP_P_COLLECT;
						widx_next = 8'h00;
					end else begin
						ridx_next = ridx_reg + 8'h01;
					end
				end
			end else if (!par_reg && !qry_reg
					&& cur == smcp_pkg::CH_QMARK) begin
				qry_next = 1'b1;
				has_next = 1'b1;
				ridx_next = ridx_reg + 8'h01;
			end else if (!par_reg && cur == smcp_pkg::CH_SPACE) begin
				par_next = 1'b1;
				has_next = 1'b1;
				ridx_next = ridx_reg + 8'h01;
			end else begin
				out_valid = 1'b1;
				if (out_ready) begin
					has_next = 1'b1;
					ridx_next = ridx_reg + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (mem_we) begin
			msg_mem[widx_reg] <= rx_char_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p_st_reg <= smcp_pkg::SMCP_P_COLLECT;
			cnt_reg <= 8'h00;
			widx_reg <= 8'h00;
			ridx_reg <= 8'h00;
			err_reg <= 1'b0;
			has_reg <= 1'b0;
			qry_reg <= 1'b0;
			par_reg <= 1'b0;
			drop_reg <= 1'b0;
		end else begin
			p_st_reg <= p_st_next;
			cnt_reg <= cnt_next;
			widx_reg <= widx_next;
			ridx_reg <= ridx_next;
			err_reg <= err_next;
			has_reg <= has_next;
			qry_reg <= qry_next;
			par_reg <= par_next;
			drop_reg <= drop_next;
		end
	end

	// response transmitter; only answers queries already parsed
	smcp_pkg::smcp_ts_t ts_reg, ts_next;
	logic [9:0]  tx_sh_reg, tx_sh_next;
	logic [15:0] tx_cnt_reg, tx_cnt_next;
	logic [3:0]  tx_nb_reg, tx_nb_next;
	logic        busy_reg, busy_next;
	logic [7:0]  pend_reg, pend_next;
	logic        load;
	logic        pend_dec;
	logic [6:0]  lch;

	assign ser_tx = tx_sh_reg[0];
	assign resp_ready = !busy_reg && ts_reg == smcp_pkg::SMCP_TS_DATA
		&& pend_reg != 8'h00;

	always_comb begin
		ts_next = ts_reg;
		tx_sh_next = tx_sh_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_nb_next = tx_nb_reg;
		busy_next = busy_reg;
		load = 1'b0;
		pend_dec = 1'b0;
		lch = resp_char;
		if (busy_reg) begin
			if (tx_cnt_reg != 16'h0000) begin
				tx_cnt_next = tx_cnt_reg - 16'h0001;
			end else begin
				tx_sh_next = {1'b1, tx_sh_reg[9:1]};
				tx_cnt_next = BIT_T;
				tx_nb_next = tx_nb_reg - 4'h1;
				busy_next = tx_nb_reg != 4'h1;
			end
		end else begin
			case (ts_reg)
				smcp_pkg::SMCP_TS_CR: begin
					load = 1'b1;
					lch = smcp_pkg::CH_CR;
					ts_next = smcp_pkg::SMCP_TS_LF;
				end
				smcp_pkg::SMCP_TS_LF: begin
					load = 1'b1;
					lch = smcp_pkg::CH_LF;
					pend_dec = 1'b1;
					ts_next = smcp_pkg::SMCP_TS_DATA;
				end
				default: begin
					load = resp_valid && resp_ready;
					if (load && resp_last) begin
						ts_next = smcp_pkg::SMCP_TS_CR;
					end
				end
			endcase
		end
		if (load) begin
			tx_sh_next = {1'b1, ~^lch, lch, 1'b0};
			tx_cnt_next = BIT_T;
			tx_nb_next = smcp_pkg::NBIT_FRAME;
			busy_next = 1'b1;
		end
		pend_next = pend_reg;
		if (beat && out_end && qry_reg && !pend_dec) begin
			pend_next = pend_reg + 8'h01;
		end else if (pend_dec && !(beat && out_end && qry_reg)) begin
			pend_next = pend_reg - 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ts_reg <= smcp_pkg::SMCP_TS_DATA;
			tx_sh_reg <= smcp_pkg::TX_IDLE_SH;
			tx_cnt_reg <= 16'h0000;
			tx_nb_reg <= 4'h0;
			busy_reg <= 1'b0;
			pend_reg <= 8'h00;
		end else begin
			ts_reg <= ts_next;
			tx_sh_reg <= tx_sh_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_nb_reg <= tx_nb_next;
			busy_reg <= busy_next;
			pend_reg <= pend_next;
		end
	end

	// checks
	sequence s_cr_out;
		load && ts_reg == smcp_pkg::SMCP_TS_CR;
	endsequence
	sequence s_lf_next;
		ts_reg == smcp_pkg::SMCP_TS_LF && busy_reg;
	endsequence

	a_tx_crlf_order: assert property (@(posedge clk) disable iff (!rst_n)
		s_cr_out |=> s_lf_next) else $error("LF does not follow CR");
	a_tx_only_query: assert property (@(posedge clk) disable iff (!rst_n)
		load |-> pend_reg != 8'h00) else $error("transmit without query");
	a_tx_start_bit: assert property (@(posedge clk) disable iff (!rst_n)
		load |=> !ser_tx && tx_sh_reg[9]) else $error("frame start or stop bad");
	a_tx_odd_par: assert property (@(posedge clk) disable iff (!rst_n)
		load |=> ^tx_sh_reg[8:1]) else $error("parity not odd");
	a_tx_frame_len: assert property (@(posedge clk) disable iff (!rst_n)
		load |=> tx_nb_reg == 4'ha) else $error("frame not ten bits");
	a_resp_prompt: assert property (@(posedge clk) disable iff (!rst_n)
		resp_valid && resp_ready |=> busy_reg && !ser_tx) else $error("late");
	a_msg_dropped: assert property (@(posedge clk) disable iff (!rst_n)
		p_st_reg == smcp_pkg::SMCP_P_COLLECT && term
		&& (err_reg || rx_bad_reg) |=> msg_drop
		&& p_st_reg == smcp_pkg::SMCP_P_COLLECT) else $error("bad msg kept");
	a_term_replay: assert property (@(posedge clk) disable iff (!rst_n)
		p_st_reg == smcp_pkg::SMCP_P_COLLECT && term && !err_reg
		&& !rx_bad_reg && cnt_reg != smcp_pkg::LEN_MAX |=>
		p_st_reg == smcp_pkg::SMCP_P_REPLAY) else $error("terminator missed");
	a_semi_split: assert property (@(posedge clk) disable iff (!rst_n)
		out_valid && !out_end |-> out_char != smcp_pkg::CH_SEMI)
		else $error("semicolon passed as data");
	a_cmd_no_reply: assert property (@(posedge clk) disable iff (!rst_n)
		beat && out_end && !out_query |=> pend_reg <= $past(pend_reg))
		else $error("command raised a reply");
endmodule : smcp_parser

// >>> smcp_host_model.sv
// host-side model: frames characters onto ser_rx and collects ser_tx frames
module smcp_host_model #(
	parameter int CPB   = 8,
	parameter int QUIET = 40
) (
	input  wire logic clk,
	output logic      ser_rx,
	input  wire logic ser_tx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] rx_q[$];
	int         bad_frames = 0;

	initial ser_rx = 1'b1;

	task automatic send_char(input logic [6:0] c, input logic bad);
		logic [9:0] fr;
		fr = {1'b1, ~^c ^ bad, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			ser_rx = fr[i];
			repeat (CPB) @(posedge clk);
			#1;
		end
	endtask : send_char

	// whole string with its terminator in one go, then stay quiet
	task automatic send_msg(input string s, input int bad_at);
		byte b;
		for (int i = 0; i < s.len(); i++) begin
			b = s[i];
			send_char(b[6:0], i == bad_at);
		end
		repeat (QUIET) @(posedge clk);
		#1;
	endtask : send_msg

	// always listening, so a response is taken from its first bit
	initial begin
		logic [9:0] fr;
		forever begin
			@(negedge ser_tx);
			repeat (CPB / 2) @(negedge clk);
			for (int i = 0; i < 10; i++) begin
				fr[i] = ser_tx;
				if (i < 9) repeat (CPB) @(negedge clk);
			end
			if (fr[0] !== 1'b0 || fr[9] !== 1'b1 || ^fr[8:1] !== 1'b1)
				bad_frames++;
			rx_q.push_back(fr[7:1]);
		end
	end
endmodule : smcp_host_model

// >>> smcp_parser_tb.sv
// self-checking bench for the serial message command parser
module smcp_parser_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPB = 8;
	logic       clk, rst_n, ser_rx, ser_tx, out_valid, out_ready;
	logic       out_param, out_end, out_query, resp_valid, resp_ready;
	logic       resp_last, msg_drop;
	logic [6:0] out_char, resp_char;
	logic [9:0] exp_q[$], got_q[$];
	int         seed = 32479;
	int         err_count = 0, check_count = 0, drop_count = 0, cycles = 0;

	smcp_parser #(.CLKS_PER_BIT(CPB)) DUT (.clk(clk), .rst_n(rst_n),
		.ser_rx(ser_rx), .ser_tx(ser_tx), .out_valid(out_valid),
		.out_ready(out_ready), .out_char(out_char), .out_param(out_param),
		.out_end(out_end), .out_query(out_query), .resp_valid(resp_valid),
		.resp_ready(resp_ready), .resp_char(resp_char),
		.resp_last(resp_last), .msg_drop(msg_drop));
	smcp_host_model #(.CPB(CPB), .QUIET(40)) host (.clk(clk),
		.ser_rx(ser_rx), .ser_tx(ser_tx));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] exp,
			input logic [15:0] seen);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict;
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			err_count++;
			print_verdict();
		end
	end

	always @(posedge clk) begin
		#1;
		out_ready = 1'($random(seed));
	end

	// sampled mid-cycle, stable until the edge that takes the beat
	always @(negedge clk) begin
		if (rst_n && out_valid === 1'b1 && out_ready)
			got_q.push_back(out_end === 1'b1 ? {1'b1, out_query, 8'h00}
				: {2'b00, out_param, out_char});
		if (msg_drop === 1'b1) drop_count++;
	end

	function automatic void model_msg(input string s);
		logic sp, q, any;
		byte  b;
		sp = 1'b0;
		q = 1'b0;
		any = 1'b0;
		for (int i = 0; i < s.len(); i++) begin
			b = s[i];
			if (b == 8'h0a || b == 8'h3b) begin
				if (any) exp_q.push_back({1'b1, q, 8'h00});
				sp = 1'b0;
				q = 1'b0;
				any = 1'b0;
			end else if (b != 8'h0d) begin
				any = 1'b1;
				if (b == 8'h3f && !sp && !q) q = 1'b1;
				else if (b == 8'h20 && !sp) sp = 1'b1;
				else exp_q.push_back({2'b00, sp, b[6:0]});
			end
		end
	endfunction : model_msg

	function automatic string rand_word(input int n);
		string w;
		w = "";
		for (int i = 0; i < n; i++) begin
			w = {w, "A"};
			w[i] = 8'(65 + ($unsigned($random(seed)) % 26));
		end
		return w;
	endfunction : rand_word

	task automatic send_resp(input string r);
		byte b;
		int  n;
		for (int i = 0; i < r.len(); i++) begin
			b = r[i];
			resp_valid = 1'b1;
			resp_char = b[6:0];
			resp_last = (i == r.len() - 1);
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (resp_ready !== 1'b1 && n < 2000);
			@(posedge clk);
			#1;
		end
		resp_valid = 1'b0;
		resp_last = 1'b0;
	endtask : send_resp

	task automatic run(input string s, input int bad_at, input int drops,
			input string r);
		string e;
		byte   b;
		if (bad_at < 0 && s.len() <= 255) model_msg(s);
		host.send_msg(s, bad_at);
		for (int n = 0; n < 3000 && got_q.size() < exp_q.size(); n++)
			@(posedge clk);
		repeat (20) @(posedge clk);
		#1;
		check("beat count", exp_q.size(), got_q.size());
		foreach (exp_q[i])
			if (i < got_q.size()) check("beat", exp_q[i], got_q[i]);
		check("drops", drops, drop_count);
		exp_q.delete();
		got_q.delete();
		drop_count = 0;
		e = "";
		if (r.len() > 0) begin
			send_resp(r);
			e = {r, "\015\n"};
		end
		for (int n = 0; n < 3000 && host.rx_q.size() < e.len(); n++)
			@(posedge clk);
		repeat (100) @(posedge clk);
		#1;
		check("tx count", e.len(), host.rx_q.size());
		foreach (host.rx_q[i])
			if (i < e.len()) begin
				b = e[i];
				check("tx char", b[6:0], host.rx_q[i]);
			end
		host.rx_q.delete();
	endtask : run

	initial begin
		string s;
		rst_n = 1'b0;
		out_ready = 1'b0;
		resp_valid = 1'b0;
		resp_char = 7'h00;
		resp_last = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check("idle tx", 1, ser_tx);
		run({rand_word(3), " 12\n"}, -1, 0, "");
		run({rand_word(2), "? 5\015\n"}, -1, 0, rand_word(3));
		run({"C;", rand_word(2), "?;;E 7\n"}, -1, 0, "Z");
		run("F 1\n", 1, 1, "");
		repeat (3) run({rand_word(4), "?\n"}, -1, 0, rand_word(2));
		s = "";
		for (int k = 0; k < 254; k++) s = {s, "x"};
		run({s, "\n"}, -1, 0, "");
		run({s, "x\n"}, -1, 1, "");
		check("tx framing", 0, host.bad_frames);
		print_verdict();
	end
endmodule : smcp_parser_tb
